// File: hdl/cms_top.sv
`timescale 1ns/10ps
`default_nettype none

// Operation
// RULE_01 - Output updates each falling edge once programmed
// RULE_02 - Output zero when negative input not below positive
// RULE_03 - Zeroing phase then comparing phase per decision
// RULE_04 - Positive sampled clock high, negative clock low
// RULE_05 - Decision appears on following falling edge
// RULE_06 - Late input step shows one cycle later
// RULE_07 - Positive step response one to two cycles
// RULE_08 - Negative step response half to 1.5 cycles
// RULE_09 - Pulses near half-cycle end may be missed
// RULE_10 - Serial mux address decoded to channel, mode, polarity
// RULE_11 - Differential pairs only adjacent channels
// RULE_12 - Four-channel single-ended uses shared negative pin
// RULE_13 - Four-channel single-ended select mapping 0,2,1,3
// RULE_14 - Two-channel single-ended polarity picks channel
// RULE_15 - Two-channel single-ended negative tied to ground
// RULE_16 - First one on data input is start bit
// RULE_17 - Two or three mux bits follow start
// RULE_18 - Eight threshold bits follow, LSB first
// RULE_19 - Pair mode: select picks pair, polarity member
// RULE_20 - Configuration held until chip select rises
module cms_top (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Serial pins
    input  wire logic        cs_n_i,
    input  wire logic        sclk_i,
    input  wire logic        serial_in_line_i,
    output logic             sdo_o,
    output logic             sdo_oe_n_o,
    // Analog front end
    input  wire logic        comp_i,
    output logic      [3:0]  pos_sel_o,
    output logic      [5:0]  neg_sel_o,
    output logic             fb_sw_o,
    output logic             pos_sw_o,
    output logic             neg_sw_o,
    output logic      [7:0]  threshold_level_o
);
    import cms_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] cs_sync_q;
    logic [1:0] clk_sync_q;
    logic [1:0] din_sync_q;
    logic [1:0] comp_sync_q;
    logic       sclk_prev_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cs_sync_q   <= 2'h3;
            clk_sync_q  <= 2'h0;
            din_sync_q  <= 2'h0;
            comp_sync_q <= 2'h0;
            sclk_prev_q <= 1'b0;
        end else begin
            cs_sync_q   <= {cs_sync_q[0], cs_n_i};
            clk_sync_q  <= {clk_sync_q[0], sclk_i};
            din_sync_q  <= {din_sync_q[0], serial_in_line_i};
            comp_sync_q <= {comp_sync_q[0], comp_i};
            sclk_prev_q <= clk_sync_q[1];
        end
    end

    logic cs_n;
    logic sclk;
    logic din;
    logic comp;
    logic sclk_rise;
    logic sclk_fall;

    assign cs_n      = cs_sync_q[1];
    assign sclk      = clk_sync_q[1];
    assign din       = din_sync_q[1];
    assign comp      = comp_sync_q[1];
    assign sclk_rise = sclk & ~sclk_prev_q;
    assign sclk_fall = ~sclk & sclk_prev_q;

    // ------------------------------------------------------------
    // Wishbone registers
    // ------------------------------------------------------------
    logic        four_q;
    logic        four_d;
    logic        ack_q;
    logic        ack_d;
    logic [31:0] rdat_q;
    logic [31:0] rdat_d;
    logic        run_four_q;
    logic        run_four_d;

    cms_state_t   state_q;
    cms_state_t   state_d;
    logic [2:0]   cnt_q;
    logic [2:0]   cnt_d;
    logic [2:0]   mux_q;
    logic [2:0]   mux_d;
    logic [7:0]   thr_q;
    logic [7:0]   thr_d;
    logic         decision_q;
    logic         decision_d;
    logic         sdo_q;
    logic         sdo_d;
    logic         oe_n_q;
    logic         oe_n_d;
    cms_switch_t  sw_q;
    cms_switch_t  sw_d;
    cms_mux_cfg_t cfg;
    cms_mux_cfg_t cfg_q;

    always_comb begin
        four_d = four_q;
        ack_d  = wb_cyc_i & wb_stb_i & ~ack_q;
        rdat_d = 32'h0000_0000;
        if (ack_d) begin
            unique case (wb_adr_i)
                CMS_ADDR_CTRL: begin
                    rdat_d[CMS_CTRL_FOUR_BIT] = four_q;
                    if (wb_we_i && wb_sel_i[0]) begin
                        four_d = wb_dat_i[CMS_CTRL_FOUR_BIT];
                    end
                end
                CMS_ADDR_STATUS: begin
                    rdat_d[CMS_STAT_PROG_BIT]   = (state_q == CMS_RUN);
                    rdat_d[CMS_STAT_RESULT_BIT] = sdo_q;
                    rdat_d[CMS_STAT_BUSY_BIT]   = (state_q != CMS_IDLE);
                end
                CMS_ADDR_CONFIG: begin
                    rdat_d[CMS_CFG_THR_LSB +: 8] = thr_q;
                    rdat_d[CMS_CFG_MUX_LSB +: 3] = mux_q;
                    rdat_d[CMS_CFG_POS_LSB +: 4] = cfg_q.pos_ch;
                    rdat_d[CMS_CFG_NEG_LSB +: 6] = cfg_q.neg_ch;
                end
                default: rdat_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            four_q <= CMS_FOUR_RST;
            ack_q  <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            four_q <= four_d;
            ack_q  <= ack_d;
            rdat_q <= rdat_d;
        end
    end

    // ------------------------------------------------------------
    // Serial programming and comparison sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_d    = state_q;
        cnt_d      = cnt_q;
        mux_d      = mux_q;
        thr_d      = thr_q;
        run_four_d = run_four_q;
        decision_d = decision_q;
        sdo_d      = sdo_q;
        oe_n_d     = oe_n_q;
        sw_d       = '0;
        if (cs_n) begin
            state_d = CMS_IDLE;
            oe_n_d  = 1'b1;
            sdo_d   = 1'b0;
        end else begin
            unique case (state_q)
                CMS_IDLE: begin
                    if (sclk_rise && din) begin                     // RULE_16
                        state_d    = CMS_ADDR;
                        cnt_d      = 3'h0;
                        mux_d      = 3'h0;
                        run_four_d = four_q;
                    end
                end
                CMS_ADDR: begin
                    if (sclk_rise) begin
                        mux_d = {mux_q[1:0], din};                  // RULE_10
                        cnt_d = cnt_q + 3'h1;
                        if (cnt_q + 3'h1 == (run_four_q ? CMS_MUX_BITS_FOUR
                                                         : CMS_MUX_BITS_TWO)) begin // RULE_17
                            state_d = CMS_CODE;
                            cnt_d   = 3'h0;
                        end
                    end
                end
                CMS_CODE: begin
                    if (sclk_rise) begin
                        thr_d = {din, thr_q[7:1]};                  // RULE_18
                        cnt_d = cnt_q + 3'h1;
                        if (cnt_q == CMS_THR_BITS_LAST) begin
                            state_d = CMS_RUN;
                            oe_n_d  = 1'b0;
                            sdo_d   = 1'b0;
                        end
                    end
                end
                CMS_RUN: begin
                    // Mux word and threshold frozen here            RULE_20
                    sw_d.fb_sw  = sclk;                             // RULE_03
                    sw_d.pos_sw = sclk;                             // RULE_04
                    sw_d.neg_sw = ~sclk;
                    // Sampled on synced edges; short pulses lost     RULE_09
                    if (sclk_rise) begin
                        decision_d = comp;                          // RULE_02 RULE_06
                    end
                    if (sclk_fall) begin
                        sdo_d = decision_q;                         // RULE_01 RULE_05 RULE_07 RULE_08
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q    <= CMS_IDLE;
            cnt_q      <= 3'h0;
            mux_q      <= 3'h0;
            thr_q      <= 8'h00;
            run_four_q <= CMS_FOUR_RST;
            decision_q <= 1'b0;
            sdo_q      <= 1'b0;
            oe_n_q     <= 1'b1;
            sw_q       <= '0;
            cfg_q      <= '0;
        end else begin
            state_q    <= state_d;
            cnt_q      <= cnt_d;
            mux_q      <= mux_d;
            thr_q      <= thr_d;
            run_four_q <= run_four_d;
            decision_q <= decision_d;
            sdo_q      <= sdo_d;
            oe_n_q     <= oe_n_d;
            sw_q       <= sw_d;
            cfg_q      <= cfg;
        end
    end

    cms_mux_decode u_decode (
        .four_ch_i  (run_four_q),
        .mux_word_i (mux_q),
        .cfg_o      (cfg)
    );

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign wb_dat_o          = rdat_q;
    assign wb_ack_o          = ack_q;
    assign sdo_o             = sdo_q;
    assign sdo_oe_n_o        = oe_n_q;
    assign pos_sel_o         = cfg_q.pos_ch;
    assign neg_sel_o         = cfg_q.neg_ch;
    assign fb_sw_o           = sw_q.fb_sw;
    assign pos_sw_o          = sw_q.pos_sw;
    assign neg_sw_o          = sw_q.neg_sw;
    assign threshold_level_o = thr_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    logic run;
    assign run = (state_q == CMS_RUN) && !cs_n;

    property p_sdo_fall;
        run && sclk_fall |=> sdo_q == $past(decision_q);
    endproperty
    a_sdo_fall: assert property (p_sdo_fall) else $error("output not updated on fall"); // RULE_01

    property p_sdo_only_fall;
        run && $past(state_q == CMS_RUN) && !$past(cs_n) && $changed(sdo_q)
            |-> $past(sclk_fall);
    endproperty
    a_sdo_only_fall: assert property (p_sdo_only_fall) else $error("output moved off edge"); // RULE_05

    property p_decide;
        run && sclk_rise |=> decision_q == $past(comp);
    endproperty
    a_decide: assert property (p_decide) else $error("decision not captured"); // RULE_02

    property p_zero_phase;
        run && sclk |=> sw_q.fb_sw && sw_q.pos_sw && !sw_q.neg_sw;
    endproperty
    a_zero_phase: assert property (p_zero_phase) else $error("zero phase switches wrong"); // RULE_03

    property p_cmp_phase;
        run && !sclk |=> !sw_q.fb_sw && !sw_q.pos_sw && sw_q.neg_sw;
    endproperty
    a_cmp_phase: assert property (p_cmp_phase) else $error("compare phase switches wrong"); // RULE_04

    property p_start;
        state_q == CMS_IDLE && !cs_n && sclk_rise && din |=> state_q == CMS_ADDR;
    endproperty
    a_start: assert property (p_start) else $error("start bit missed"); // RULE_16

    property p_hold;
        run && $past(run) |-> $stable(thr_q) && $stable(mux_q);
    endproperty
    a_hold: assert property (p_hold) else $error("config changed while running"); // RULE_20

    property p_pair;
        run && !cfg_q.single_or_pair_bit
            |-> cfg_q.neg_ch[3:0] == {cfg_q.pos_ch[2], cfg_q.pos_ch[3],
                                      cfg_q.pos_ch[0], cfg_q.pos_ch[1]};
    endproperty
    a_pair: assert property (p_pair) else $error("pair not adjacent"); // RULE_11

    property p_se_neg;
        run && cfg_q.single_or_pair_bit
            |-> cfg_q.neg_ch == (run_four_q ? 6'h10 : 6'h20);
    endproperty
    a_se_neg: assert property (p_se_neg) else $error("single-ended negative wrong"); // RULE_12

    property p_se_four;
        run && run_four_q && mux_q[2]
            |-> cfg_q.pos_ch == (4'h1 << {mux_q[0], mux_q[1]});
    endproperty
    a_se_four: assert property (p_se_four) else $error("four-channel map wrong"); // RULE_13

    property p_release;
        cs_n |=> oe_n_q;
    endproperty
    a_release: assert property (p_release) else $error("output still driven"); // Output released while chip select high

endmodule

`default_nettype wire

// File: hdl/cms_pkg.sv
package cms_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [3:0] CMS_ADDR_CTRL   = 4'h0;
    localparam logic [3:0] CMS_ADDR_STATUS = 4'h4;
    localparam logic [3:0] CMS_ADDR_CONFIG = 4'h8;

    localparam int CMS_CTRL_FOUR_BIT   = 0;
    localparam int CMS_STAT_PROG_BIT   = 0;
    localparam int CMS_STAT_RESULT_BIT = 1;
    localparam int CMS_STAT_BUSY_BIT   = 2;
    localparam int CMS_CFG_THR_LSB     = 0;
    localparam int CMS_CFG_MUX_LSB     = 8;
    localparam int CMS_CFG_POS_LSB     = 16;
    localparam int CMS_CFG_NEG_LSB     = 20;

    localparam logic CMS_FOUR_RST = 1'b1;

    // ------------------------------------------------------------
    // Serial framing counts
    // ------------------------------------------------------------
    localparam logic [2:0] CMS_MUX_BITS_TWO  = 3'h2;
    localparam logic [2:0] CMS_MUX_BITS_FOUR = 3'h3;
    localparam logic [2:0] CMS_THR_BITS_LAST = 3'h7;

    // Negative select one-hot positions beyond the four channels
    localparam int CMS_NEG_SHARED = 4;
    localparam int CMS_NEG_GROUND = 5;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CMS_IDLE = 2'b00,
        CMS_ADDR = 2'b01,
        CMS_CODE = 2'b11,
        CMS_RUN  = 2'b10
    } cms_state_t;

    typedef struct packed {
        logic       single_or_pair_bit;
        logic [3:0] pos_ch;
        logic [5:0] neg_ch;
    } cms_mux_cfg_t;

    typedef struct packed {
        logic fb_sw;
        logic pos_sw;
        logic neg_sw;
    } cms_switch_t;

endpackage

// File: hdl/cms_mux_decode.sv
`timescale 1ns/10ps
`default_nettype none

module cms_mux_decode (
    input  wire logic                  four_ch_i,
    input  wire logic [2:0]            mux_word_i,
    output var cms_pkg::cms_mux_cfg_t  cfg_o
);
    import cms_pkg::*;

    logic       sgl;
    logic       pol;
    logic       sel;
    logic [1:0] pos_idx;

    always_comb begin
        cfg_o = '0;
        if (four_ch_i) begin
            sgl = mux_word_i[2];
            pol = mux_word_i[1];
            sel = mux_word_i[0];
        end else begin
            sgl = mux_word_i[1];
            pol = mux_word_i[0];
            sel = 1'b0;
        end
        pos_idx = {sel, pol};                                       // RULE_13
        cfg_o.single_or_pair_bit = sgl;
        cfg_o.pos_ch = 4'h1 << pos_idx;                             // RULE_14
        if (sgl) begin
            if (four_ch_i) begin
                cfg_o.neg_ch[CMS_NEG_SHARED] = 1'b1;                // RULE_12
            end else begin
                cfg_o.neg_ch[CMS_NEG_GROUND] = 1'b1;                // RULE_15
            end
        end else begin
            cfg_o.neg_ch[3:0] = 4'h1 << {sel, ~pol};                // RULE_11 RULE_19
        end
    end

endmodule

`default_nettype wire

// File: verif/cms_host_model.sv
`timescale 1ns/10ps
`default_nettype none

module cms_host_model #(
    parameter int HALF = 8
) (
    input  wire logic clk_i,
    output logic      cs_n_o,
    output logic      sclk_o,
    output logic      di_o
);
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        di_o   = 1'b0;
    end

    // ----------------------------------------
    // One half period of the serial clock
    // ----------------------------------------
    task automatic phase(input logic lvl, input logic d);
        sclk_o <= lvl;
        di_o   <= d;
        repeat (HALF) @(posedge clk_i);
    endtask

    // ----------------------------------------
    // Frame: zeros, start, mux bits, threshold
    // ----------------------------------------
    task automatic send_frame(input logic four, input logic [2:0] mux, input logic [7:0] thr);
        logic b [$];
        b = '{1'b0, 1'b0, 1'b0, 1'b1};
        b.push_back(mux[2]);
        b.push_back(mux[1]);
        if (four) begin
            b.push_back(mux[0]);
        end
        for (int i = 0; i < 8; i++) begin
            b.push_back(thr[i]);
        end
        cs_n_o <= 1'b0;
        phase(1'b0, 1'b0);
        foreach (b[i]) begin
            phase(1'b0, b[i]);
            phase(1'b1, b[i]);
        end
    endtask

    // ----------------------------------------
    // Close the frame, line released
    // ----------------------------------------
    task automatic end_frame();
        phase(1'b0, ~di_o);
        cs_n_o <= 1'b1;
        di_o   <= ~di_o;
        repeat (HALF) @(posedge clk_i);
    endtask
endmodule

`default_nettype wire

// File: verif/tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module tb_top;
    import cms_pkg::*;

    typedef struct packed {
        logic       four;
        logic [2:0] mux;
        logic [3:0] pos;
        logic [5:0] neg;
        logic [7:0] thr;
        logic       cmp;
    } cms_row_t;

    logic        clk_i;
    logic        rst_i;
    logic        wb_cyc_i;
    logic        wb_stb_i;
    logic        wb_we_i;
    logic [3:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        cs_n;
    logic        sclk;
    logic        di;
    logic        sdo_o;
    logic        sdo_oe_n_o;
    logic        comp_i;
    logic [3:0]  pos_sel_o;
    logic [5:0]  neg_sel_o;
    logic        fb_sw_o;
    logic        pos_sw_o;
    logic        neg_sw_o;
    logic [7:0]  threshold_level_o;
    int          n_fail;
    int          n_tests;
    logic [31:0] q;
    cms_row_t    r;
    cms_row_t    rows [12];

    cms_top u_cms_top (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cs_n_i(cs_n), .sclk_i(sclk),
        .serial_in_line_i(di), .sdo_o(sdo_o), .sdo_oe_n_o(sdo_oe_n_o), .comp_i(comp_i),
        .pos_sel_o(pos_sel_o), .neg_sel_o(neg_sel_o), .fb_sw_o(fb_sw_o),
        .pos_sw_o(pos_sw_o), .neg_sw_o(neg_sw_o), .threshold_level_o(threshold_level_o)
    );

    cms_host_model u_cms_host_model (
        .clk_i(clk_i), .cs_n_o(cs_n), .sclk_o(sclk), .di_o(di)
    );

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    // ----------------------------------------
    // Compare, bus cycle, verdict
    // ----------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask

    task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_dat_i <= d;
        wb_sel_i <= 4'hF;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1 && n < 20) begin
            n++;
            @(posedge clk_i);
        end
        if (n == 20) begin
            n_fail++;
        end
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask

    task automatic close_out();
        $display("Checks %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge clk_i);
        n_fail++;
        close_out();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        rows = '{
            '{1'b1, 3'h4, 4'h1, 6'h10, 8'h01, 1'b1}, '{1'b1, 3'h5, 4'h4, 6'h10, 8'h80, 1'b0},
            '{1'b1, 3'h6, 4'h2, 6'h10, 8'hA5, 1'b1}, '{1'b1, 3'h7, 4'h8, 6'h10, 8'h5A, 1'b0},
            '{1'b1, 3'h0, 4'h1, 6'h02, 8'hFF, 1'b1}, '{1'b1, 3'h1, 4'h4, 6'h08, 8'h00, 1'b0},
            '{1'b1, 3'h2, 4'h2, 6'h01, 8'h3C, 1'b1}, '{1'b1, 3'h3, 4'h8, 6'h04, 8'hC3, 1'b0},
            '{1'b0, 3'h4, 4'h1, 6'h20, 8'h7E, 1'b1}, '{1'b0, 3'h6, 4'h2, 6'h20, 8'h81, 1'b0},
            '{1'b0, 3'h0, 4'h1, 6'h02, 8'h96, 1'b1}, '{1'b0, 3'h2, 4'h2, 6'h01, 8'h69, 1'b0}};
        n_fail   = 0;
        n_tests  = 0;
        rst_i    = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i  = 1'b0;
        wb_adr_i = 4'h0;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0;
        comp_i   = 1'b0;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        #1;
        chk(32'({sdo_oe_n_o, sdo_o, fb_sw_o, pos_sw_o, neg_sw_o}), 32'h10);
        chk(32'(threshold_level_o), 32'h0);
        wb(1'b0, CMS_ADDR_CTRL, 32'h0);
        chk(32'(q[0]), 32'(CMS_FOUR_RST));
        wb(1'b1, 4'hC, 32'hFFFFFFFF);
        wb(1'b0, 4'hC, 32'h0);
        chk(q, 32'h0);
        foreach (rows[i]) begin
            r = rows[i];
            wb(1'b1, CMS_ADDR_CTRL, 32'(r.four));
            comp_i <= r.cmp;
            u_cms_host_model.send_frame(r.four, r.mux, r.thr);
            #1;
            chk(32'({pos_sel_o, neg_sel_o}), 32'({r.pos, r.neg}));
            chk(32'(threshold_level_o), 32'(r.thr));
            for (int k = 0; k < 3; k++) begin
                u_cms_host_model.phase(1'b0, k[0]);
                #1;
                chk(32'({fb_sw_o, pos_sw_o, neg_sw_o}), 32'h1);
                chk(32'(sdo_oe_n_o), 32'h0);
                u_cms_host_model.phase(1'b1, ~k[0]);
                #1;
                chk(32'({fb_sw_o, pos_sw_o, neg_sw_o}), 32'h6);
            end
            chk(32'(sdo_o), 32'(r.cmp));
            wb(1'b0, CMS_ADDR_STATUS, 32'h0);
            chk(32'(q[2:0]), 32'({1'b1, r.cmp, 1'b1}));
            comp_i <= ~r.cmp;
            u_cms_host_model.phase(1'b0, 1'b1);
            #1;
            chk(32'(sdo_o), 32'(r.cmp));
            u_cms_host_model.phase(1'b1, 1'b0);
            u_cms_host_model.phase(1'b0, 1'b1);
            #1;
            chk(32'(sdo_o), 32'(!r.cmp));
            wb(1'b0, CMS_ADDR_CONFIG, 32'h0);
            chk(q & 32'h03FF07FF, {6'h0, r.neg, r.pos, 5'h00,
                (r.four ? r.mux : {1'b0, r.mux[2:1]}), r.thr});
            u_cms_host_model.end_frame();
            #1;
            chk(32'({sdo_oe_n_o, sdo_o}), 32'h2);
        end
        // Reset in mid-run, frame cut afterwards
        u_cms_host_model.send_frame(1'b0, 3'h4, 8'h33);
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        #1;
        chk(32'({sdo_oe_n_o, sdo_o, fb_sw_o, pos_sw_o, neg_sw_o}), 32'h10);
        chk(32'(threshold_level_o), 32'h0);
        wb(1'b0, CMS_ADDR_STATUS, 32'h0);
        chk(32'(q[2:0]), 32'h0);
        wb(1'b0, CMS_ADDR_CTRL, 32'h0);
        chk(32'(q[0]), 32'(CMS_FOUR_RST));
        u_cms_host_model.end_frame();
        close_out();
    end
endmodule

`default_nettype wire
